// [src/srx_status.sv]
// receive status, buffer and register file of the serial interface
// assumes an apb master on CLK; RXD is synchronous to CLK
//
// Operation
// - character completing while receive-full still set flags overrun
// - a received break is reported as a framing error
// - idle frame sets idle flag; interrupt when idle enable and unmasked
// - status bits txe,tc,rxf,idle,or,nf,fe,pe; reset c0
// - control two holds interrupt, enable, wakeup, break bits; reset 0
// - control one holds ninth bits, disable, length, parity; reset 0
// - baud register: prescaler 7:6, transmit 5:3, receive 2:0
// - received character sets receive-full and may interrupt
// - data enters lsb first; ninth bit goes into control one
`timescale 1ns/1ps
module srx_status
    import srx_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        RXD,
    input  wire logic        I_MASK,
    output logic             IRQ
);

    typedef struct packed {
        logic        rxf;
        logic        idle;
        logic        ovr;
        logic        nf;
        logic        fe;
        logic        pe;
        logic        armed;
        logic [7:0]  rx_buf;
        logic [7:0]  tx_buf;
        logic [7:0]  baud;
        logic [7:0]  ctl1;
        logic [7:0]  ctl2;
        logic [7:0]  erpr;
        logic [7:0]  etpr;
        logic [3:0]  irq_stat;
        logic [3:0]  irq_mask;
        logic [15:0] period;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
    } srx_top_t;

    srx_top_t  s_r;
    srx_top_t  s_nxt;
    srx_sel_t  sel;
    logic      setup;
    logic      acc;
    logic      clr;
    logic      take;
    logic      mute;
    logic      msb;
    logic      rx_done;
    logic      rx_idle;
    logic [8:0] rx_word;
    logic      rx_fe;
    logic      rx_nf;
    logic      rx_pe;
    logic [3:0] src_en;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // misaligned or unmapped addresses decode to nothing
    function automatic srx_sel_t srx_decode(input logic [11:0] a);
        srx_sel_t sl;
        sl = SEL_NONE;
        if (a[1:0] == 2'b00) begin
            case (a[11:2])
                IDX_STATUS: sl = SEL_STATUS;
                IDX_DATA:   sl = SEL_DATA;
                IDX_BAUD:   sl = SEL_BAUD;
                IDX_CTL1:   sl = SEL_CTL1;
                IDX_CTL2:   sl = SEL_CTL2;
                IDX_ERPR:   sl = SEL_ERPR;
                IDX_ETPR:   sl = SEL_ETPR;
                IDX_ISTAT:  sl = SEL_ISTAT;
                IDX_IMASK:  sl = SEL_IMASK;
                default:    sl = SEL_NONE;
            endcase
        end
        return sl;
    endfunction : srx_decode

    // bit time grows with the common prescaler, doubles per receive step
    function automatic logic [15:0] srx_period(input logic [7:0] b);
        logic [15:0] p;
        p = 16'(BIT_UNIT_CYC * {14'h0, b[7:6]} + BIT_UNIT_CYC);
        return 16'(p << b[2:0]);
    endfunction : srx_period

    function automatic logic [7:0] srx_status_byte(input srx_top_t s);
        return {STATUS_RST[7:6], s.rxf, s.idle, s.ovr, s.nf, s.fe, s.pe};
    endfunction : srx_status_byte

    assign sel    = srx_decode(PADDR);
    assign setup  = PSEL && !PENABLE;
    assign acc    = PSEL && PENABLE && s_r.pready;
    assign clr    = acc && !PWRITE && sel == SEL_DATA && s_r.armed;
    assign mute   = s_r.ctl2[C2_RWU];
    assign msb    = s_r.ctl1[C1_M] ? rx_word[8] : rx_word[7];
    // in wakeup mode only an address mark gets through, and only with address-mark wake selected
    assign take   = rx_done && (!mute || (s_r.ctl1[C1_WAKE] && msb));
    // receive-full and the error event share the receive enable
    assign src_en = {s_r.ctl1[C1_PIE], s_r.ctl2[C2_RIE],
                     s_r.ctl2[C2_IDLE_IRQ_ENABLE], s_r.ctl2[C2_RIE]};

    // ------------------------------------------------------------
    // bit receiver
    // ------------------------------------------------------------
    srx_bit_rx u_rx (
        .clk     (CLK),
        .rst_b   (RST_B),
        .rxd     (RXD),
        .en      (s_r.ctl2[C2_RE] && !s_r.ctl1[C1_INTERFACE_DISABLE]),
        .nine    (s_r.ctl1[C1_M]),
        .par_en  (s_r.ctl1[C1_PCE]),
        .par_odd (s_r.ctl1[C1_PS]),
        .period  (s_r.period),
        .done    (rx_done),
        .idle    (rx_idle),
        .word    (rx_word),
        .fe      (rx_fe),
        .nf      (rx_nf),
        .pe      (rx_pe)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt        = s_r;
        // one wait-free access: ready rises for the access phase only
        s_nxt.pready = setup;
        s_nxt.period = srx_period(s_r.baud);

        if (setup) begin
            s_nxt.pslverr = (sel == SEL_NONE);
            case (sel)
                SEL_STATUS: s_nxt.prdata = {24'h0, srx_status_byte(s_r)};
                SEL_DATA:   s_nxt.prdata = {24'h0, s_r.rx_buf};
                SEL_BAUD:   s_nxt.prdata = {24'h0, s_r.baud};
                SEL_CTL1:   s_nxt.prdata = {24'h0, s_r.ctl1};
                SEL_CTL2:   s_nxt.prdata = {24'h0, s_r.ctl2};
                SEL_ERPR:   s_nxt.prdata = {24'h0, s_r.erpr};
                SEL_ETPR:   s_nxt.prdata = {24'h0, s_r.etpr};
                SEL_ISTAT:  s_nxt.prdata = {28'h0, s_r.irq_stat};
                SEL_IMASK:  s_nxt.prdata = {28'h0, s_r.irq_mask};
                default:    s_nxt.prdata = 32'h0;
            endcase
        end

        // first step of the clearing sequence: any status access
        if (acc && sel == SEL_STATUS) s_nxt.armed = 1'b1;
        if (clr) begin
            s_nxt.armed = 1'b0;
            s_nxt.rxf   = 1'b0;
            s_nxt.idle  = 1'b0;
            s_nxt.ovr   = 1'b0;
            s_nxt.nf    = 1'b0;
            s_nxt.fe    = 1'b0;
            s_nxt.pe    = 1'b0;
        end

        // status writes fall into the default branch: it is read-only
        if (acc && PWRITE) begin
            case (sel)
                SEL_DATA: s_nxt.tx_buf = PWDATA[7:0];
                SEL_BAUD: s_nxt.baud = PWDATA[7:0];
                // received ninth bit is written by hardware only
                SEL_CTL1: s_nxt.ctl1 = {s_r.ctl1[C1_R8], PWDATA[6:0]};
                SEL_CTL2: s_nxt.ctl2 = PWDATA[7:0];
                SEL_ERPR: s_nxt.erpr = PWDATA[7:0];
                SEL_ETPR: s_nxt.etpr = PWDATA[7:0];
                SEL_ISTAT: s_nxt.irq_stat = s_r.irq_stat & ~PWDATA[3:0];
                SEL_IMASK: s_nxt.irq_mask = PWDATA[3:0];
                default: s_nxt.baud = s_r.baud;
            endcase
        end

        // ------------------------------------------------------------
        // receive events; they come after the clears so a set wins
        // ------------------------------------------------------------
        if (rx_idle) begin
            // wakeup by idle line only releases the mute, flags stay
            if (mute && !s_r.ctl1[C1_WAKE]) begin
                s_nxt.ctl2[C2_RWU] = 1'b0;
            end else begin
                s_nxt.idle              = 1'b1;
                s_nxt.armed             = 1'b0;
                s_nxt.irq_stat[IQ_IDLE] = 1'b1;
            end
        end

        if (take) begin
            // a fresh status access is needed before the next clear
            s_nxt.armed        = 1'b0;
            s_nxt.ctl2[C2_RWU] = 1'b0;
            if (s_r.rxf && !clr) begin
                // buffer still unread: new character is lost
                s_nxt.ovr              = 1'b1;
                s_nxt.irq_stat[IQ_ERR] = 1'b1;
            end else begin
                s_nxt.rxf    = 1'b1;
                s_nxt.rx_buf = rx_word[7:0];
                if (s_r.ctl1[C1_M]) s_nxt.ctl1[C1_R8] = rx_word[8];
                s_nxt.fe     = rx_fe;
                s_nxt.nf     = rx_nf;
                s_nxt.pe     = rx_pe;
                s_nxt.irq_stat[IQ_RXF] = 1'b1;
                if (rx_fe || rx_nf) s_nxt.irq_stat[IQ_ERR] = 1'b1;
                if (rx_pe) s_nxt.irq_stat[IQ_PE] = 1'b1;
            end
        end

        // cpu-wide mask blocks the line but keeps events pending
        s_nxt.irq = !I_MASK && |(s_r.irq_stat & s_r.irq_mask & src_en);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // receive buffer resets to zero so a first read is never unknown
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            s_r <= '{rx_buf: DATA_RST, tx_buf: DATA_RST, baud: BAUD_RST,
                     ctl1: CTL1_RST, ctl2: CTL2_RST, erpr: PRE_RST,
                     etpr: PRE_RST, irq_mask: IMASK_RST,
                     period: BIT_UNIT_CYC, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign PRDATA  = s_r.prdata;
    assign PREADY  = s_r.pready;
    assign PSLVERR = s_r.pslverr;
    assign IRQ     = s_r.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    chk_status_layout: assert property (
        (setup && sel == SEL_STATUS) |=>
            (PRDATA[31:6] == 26'h3 && PRDATA[5] == $past(s_r.rxf)))
        else $error("status read lost its transmit flags or layout");
    chk_clear_seq: assert property (
        (clr && !rx_done) |=> (!s_r.rxf && !s_r.ovr && !s_r.armed))
        else $error("status then data read did not clear the flags");
    chk_no_clear_unarmed: assert property (
        (s_r.rxf && !s_r.armed && !(acc && sel == SEL_STATUS)) |=> s_r.rxf)
        else $error("receive-full cleared without a status access");
    chk_overrun_set: assert property (
        (take && s_r.rxf && !clr) |=>
            (s_r.ovr && s_r.rx_buf == $past(s_r.rx_buf)))
        else $error("overrun not flagged or buffer overwritten");
    chk_rx_full_set: assert property (
        (take && !s_r.rxf) |=> (s_r.rxf && s_r.rx_buf == $past(rx_word[7:0])))
        else $error("received character not moved into the buffer");
    chk_idle_irq: assert property (
        (rx_idle && (!mute || s_r.ctl1[C1_WAKE]) && s_r.ctl2[C2_IDLE_IRQ_ENABLE] &&
         s_r.irq_mask[IQ_IDLE] && !I_MASK) ##1 !I_MASK
            |=> IRQ)
        else $error("enabled idle frame gave no interrupt");
    chk_ninth_bit: assert property (
        (take && !s_r.rxf && s_r.ctl1[C1_M]) |=>
            s_r.ctl1[C1_R8] == $past(rx_word[8]))
        else $error("ninth received bit not stored");
    chk_ctl1_write: assert property (
        (acc && PWRITE && sel == SEL_CTL1 && !take) |=>
            (s_r.ctl1 == {$past(s_r.ctl1[7]), $past(PWDATA[6:0])}))
        else $error("control one write wrong or touched ninth bit");
    chk_ctl2_write: assert property (
        (acc && PWRITE && sel == SEL_CTL2 && !take && !rx_idle) |=>
            s_r.ctl2 == $past(PWDATA[7:0]))
        else $error("control two write not stored");
    chk_baud_write: assert property (
        (acc && PWRITE && sel == SEL_BAUD) |=> ##1
            s_r.period == srx_period(s_r.baud))
        else $error("bit period does not follow the baud register");
    chk_data_read: assert property (
        (setup && sel == SEL_DATA) |=> PRDATA == {24'h0, $past(s_r.rx_buf)})
        else $error("data read did not return the receive buffer");

    // ------------------------------------------------------------
    // flag and interrupt checks
    // ------------------------------------------------------------
    // irq checks look one edge past the pending bit, IRQ is registered
    chk_idle_flag: assert property (
        (rx_idle && (!mute || s_r.ctl1[C1_WAKE])) |=>
            (s_r.idle && s_r.irq_stat[IQ_IDLE]))
        else $error("idle frame did not set its flags");
    chk_overrun_irq: assert property (
        (take && s_r.rxf && !clr) |=>
            s_r.irq_stat[IQ_ERR])
        else $error("overrun raised no error event");
    chk_break_event: assert property (
        (take && !s_r.rxf && rx_fe) |=>
            (s_r.fe && s_r.irq_stat[IQ_ERR]))
        else $error("break did not flag a framing error");
    chk_rx_flags: assert property (
        (take && !s_r.rxf) |=>
            (s_r.nf == $past(rx_nf) && s_r.pe == $past(rx_pe)))
        else $error("receive error flags not taken with the character");
    chk_rx_irq: assert property (
        (s_r.irq_stat[IQ_RXF] && s_r.irq_mask[IQ_RXF] &&
         s_r.ctl2[C2_RIE] && !I_MASK) |=> IRQ)
        else $error("pending receive event gave no interrupt");
    // the cpu-wide mask holds the line low whatever is pending
    chk_mask_blocks: assert property (
        I_MASK |=> !IRQ)
        else $error("interrupt raised while the cpu mask was set");
    chk_clear_all: assert property (
        (clr && !rx_done && !rx_idle) |=>
            !(s_r.idle || s_r.nf || s_r.fe || s_r.pe))
        else $error("clear sequence left an error or idle flag set");

    // main scenarios: overrun, idle, break, clear then receive, parity
    cov_overrun: cover property (take && s_r.rxf && !clr);
    cov_idle:    cover property (rx_idle && s_r.ctl2[C2_IDLE_IRQ_ENABLE]);
    cov_break:   cover property (take && rx_fe && rx_word == 9'h000);
    cov_clear:   cover property (clr ##1 take);
    cov_parity:  cover property (take && rx_pe);

endmodule : srx_status

// [src/srx_pkg.sv]
// constants shared by the serial receive status block and its bit receiver
// assumes a 20 MHz system clock and an apb master with 32-bit data
package srx_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned BIT_UNIT_NS   = 800;
    localparam logic [15:0] BIT_UNIT_CYC  =
        16'((BIT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_STATUS = 10'h050;
    localparam logic [9:0] IDX_DATA   = 10'h051;
    localparam logic [9:0] IDX_BAUD   = 10'h052;
    localparam logic [9:0] IDX_CTL1   = 10'h053;
    localparam logic [9:0] IDX_CTL2   = 10'h054;
    localparam logic [9:0] IDX_ERPR   = 10'h055;
    localparam logic [9:0] IDX_ETPR   = 10'h057;
    localparam logic [9:0] IDX_ISTAT  = 10'h058;
    localparam logic [9:0] IDX_IMASK  = 10'h059;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_RST = 8'hc0;
    localparam logic [7:0] BAUD_RST   = 8'h00;
    localparam logic [7:0] CTL1_RST   = 8'h00;
    localparam logic [7:0] CTL2_RST   = 8'h00;
    localparam logic [7:0] PRE_RST    = 8'h00;
    localparam logic [7:0] DATA_RST   = 8'h00;
    localparam logic [3:0] IMASK_RST  = 4'h0;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int C1_R8   = 7;
    localparam int C1_INTERFACE_DISABLE = 5;
    localparam int C1_M    = 4;
    localparam int C1_WAKE = 3;
    localparam int C1_PCE  = 2;
    localparam int C1_PS   = 1;
    localparam int C1_PIE  = 0;
    localparam int C2_RIE  = 5;
    localparam int C2_IDLE_IRQ_ENABLE = 4;
    localparam int C2_RE   = 2;
    localparam int C2_RWU  = 1;
    localparam int IQ_RXF  = 0;
    localparam int IQ_IDLE = 1;
    localparam int IQ_ERR  = 2;
    localparam int IQ_PE   = 3;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b11,
        RX_STOP  = 2'b10
    } srx_rx_state_t;

    typedef enum logic [3:0] {
        SEL_NONE, SEL_STATUS, SEL_DATA, SEL_BAUD, SEL_CTL1,
        SEL_CTL2, SEL_ERPR, SEL_ETPR, SEL_ISTAT, SEL_IMASK
    } srx_sel_t;

endpackage : srx_pkg

// [src/srx_bit_rx.sv]
// bit receiver: start detect, lsb-first shifting, stop check, idle frames
// assumes rxd is synchronous to clk and period is at least four cycles
`timescale 1ns/1ps
module srx_bit_rx
    import srx_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        rxd,
    input  wire logic        en,
    input  wire logic        nine,
    input  wire logic        par_en,
    input  wire logic        par_odd,
    input  wire logic [15:0] period,
    output logic             done,
    output logic             idle,
    output logic [8:0]       word,
    output logic             fe,
    output logic             nf,
    output logic             pe
);

    typedef struct packed {
        srx_rx_state_t st;
        logic [15:0]   cnt;
        logic [3:0]    bits;
        logic [3:0]    idles;
        logic [8:0]    shf;
        logic          pre;
        logic          line;
        logic          noise;
        logic          armed;
        logic          done;
        logic          idle;
        logic [8:0]    word;
        logic          fe;
        logic          nf;
        logic          pe;
    } srx_rx_t;

    srx_rx_t     r;
    srx_rx_t     n;
    logic [15:0] half;
    logic [15:0] last;
    logic [3:0]  nb;
    logic [8:0]  w;

    assign half = {1'b0, period[15:1]};
    assign last = 16'(period - 16'h1);
    assign nb   = nine ? 4'h9 : 4'h8;
    assign w    = nine ? r.shf : {1'b0, r.shf[8:1]};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n      = r;
        n.done = 1'b0;
        n.idle = 1'b0;
        n.line = rxd;
        n.cnt  = 16'(r.cnt + 16'h1);
        // two samples around mid-bit; disagreement counts as noise
        if (r.cnt == 16'(half - 16'h1)) n.pre = rxd;
        if (r.cnt == half && r.st != RX_IDLE && rxd != r.pre)
            n.noise = 1'b1;
        case (r.st)
            RX_IDLE: begin
                if (!rxd) begin
                    n.cnt   = 16'h0;
                    n.idles = 4'h0;
                    n.noise = 1'b0;
                    if (r.line && en) n.st = RX_START;
                end else if (r.cnt == last) begin
                    n.cnt = 16'h0;
                    if (r.armed) n.idles = 4'(r.idles + 4'h1);
                end
                // a whole frame of high line after a character
                if (r.armed && r.idles == 4'(nb + 4'h2)) begin
                    n.idle  = 1'b1;
                    n.armed = 1'b0;
                    n.idles = 4'h0;
                end
            end
            RX_START: begin
                if (r.cnt == half && rxd) begin
                    n.st = RX_IDLE;
                end else if (r.cnt == last) begin
                    n.st   = RX_DATA;
                    n.cnt  = 16'h0;
                    n.bits = 4'h0;
                end
            end
            RX_DATA: begin
                if (r.cnt == half) n.shf = {rxd, r.shf[8:1]};
                if (r.cnt == last) begin
                    n.cnt  = 16'h0;
                    n.bits = 4'(r.bits + 4'h1);
                    if (r.bits == 4'(nb - 4'h1)) n.st = RX_STOP;
                end
            end
            RX_STOP: begin
                if (r.cnt == half) begin
                    n.done  = 1'b1;
                    n.fe    = !rxd;
                    n.nf    = n.noise;
                    n.word  = w;
                    n.pe    = par_en && ((^w) != par_odd);
                    n.st    = RX_IDLE;
                    n.cnt   = 16'h0;
                    n.idles = 4'h0;
                    n.armed = 1'b1;
                end
            end
            default: n.st = RX_IDLE;
        endcase
        if (!en) begin
            n.st    = RX_IDLE;
            n.armed = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) r <= '{st: RX_IDLE, default: '0};
        else        r <= n;
    end

    assign done = r.done;
    assign idle = r.idle;
    assign word = r.word;
    assign fe   = r.fe;
    assign nf   = r.nf;
    assign pe   = r.pe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_break_framing: assert property (
        (r.st == RX_STOP && r.cnt == half && !rxd && en) |=> (done && fe))
        else $error("low stop bit did not give a framing error");
    chk_lsb_first: assert property (
        (r.st == RX_DATA && r.cnt == half && en) |=> r.shf[8] == $past(rxd))
        else $error("received bit not shifted in at the top");

endmodule : srx_bit_rx

// [verif/srx_line_tx.sv]
// remote serial transmitter driving the receive line
// assumes start is held until busy is seen high
`timescale 1ns/1ps
module srx_line_tx (
    input  wire logic        clk,
    input  wire logic        start,
    input  wire logic [8:0]  word,
    input  wire logic        nine,
    input  wire logic        brk,
    input  wire logic [15:0] period,
    output logic             rxd,
    output logic             busy
);
    // ----
    // frame sender
    // ----
    int i;
    initial begin
        rxd = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (start) begin
                busy <= 1'b1;
                for (i = 0; i < 10 + nine; i++) begin
                    if (i == 0) rxd <= 1'b0;
                    else if (i <= 8 + nine) rxd <= word[i-1] & ~brk;
                    else rxd <= ~brk;
                    repeat (period) @(posedge clk);
                end
                // line idles high between frames, as a pulled-up line would
                rxd <= 1'b1;
                busy <= 1'b0;
            end
        end
    end
endmodule : srx_line_tx

// [verif/test_srx_status.sv]
// self-checking bench for the serial receive status block
// assumes the line model on RXD and an apb slave on the bus
`timescale 1ns/1ps
module test_srx_status import srx_pkg::*; ;
    // ----
    // signals and instances
    // ----
    logic        clk, rst_b, psel, penable, pwrite, i_mask;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, irq, rxd, start, nine, brk, busy, err;
    logic [8:0]  word;
    int          mismatches, total_checks;

    srx_status u_dut (.CLK(clk), .RST_B(rst_b), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .RXD(rxd), .I_MASK(i_mask), .IRQ(irq));
    // baud register at 00h gives a 16-cycle bit
    srx_line_tx u_line (.clk(clk), .start(start), .word(word),
        .nine(nine), .brk(brk), .period(16'd16), .rxd(rxd), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ----
    // shared tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [9:0] idx,
                       input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // read before the edge's updates land: the value the edge samples
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask : rdc

    task automatic send(input logic [8:0] w, input logic b);
        @(posedge clk);
        word <= w;
        brk <= b;
        start <= 1'b1;
        wait (busy === 1'b1);
        @(posedge clk);
        start <= 1'b0;
        wait (busy === 1'b0);
        repeat (4) @(posedge clk);
    endtask : send

    task automatic settle();
        repeat (200) @(posedge clk);
        apb(1'b0, IDX_STATUS, 32'h0);
        apb(1'b0, IDX_DATA, 32'h0);
        apb(1'b1, IDX_ISTAT, 32'hf);
    endtask : settle
    // ----
    // scenarios
    // ----
    task automatic t_reset();
        logic [9:0] ix [6] = '{IDX_STATUS, IDX_BAUD, IDX_CTL1,
                               IDX_CTL2, IDX_ERPR, IDX_ETPR};
        logic [7:0] rv [6] = '{8'hc0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        foreach (ix[k]) rdc(ix[k], {24'h0, rv[k]});
        apb(1'b0, 10'h056, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask : t_reset

    task automatic t_regs();
        apb(1'b1, IDX_STATUS, 32'hff);
        rdc(IDX_STATUS, 32'hc0);
        apb(1'b1, IDX_BAUD, 32'hc9);
        rdc(IDX_BAUD, 32'hc9);
        apb(1'b1, IDX_BAUD, 32'h0);
        apb(1'b1, IDX_CTL1, 32'hff);
        rdc(IDX_CTL1, 32'h7f);
        apb(1'b1, IDX_CTL1, 32'h0);
        apb(1'b1, IDX_DATA, 32'h77);
        rdc(IDX_DATA, 32'h0);
        apb(1'b1, IDX_CTL2, 32'h34);
        rdc(IDX_CTL2, 32'h34);
        apb(1'b1, IDX_IMASK, 32'h3);
    endtask : t_regs

    task automatic t_rx();
        send(9'h0a5, 1'b0);
        chk({31'h0, irq}, 32'h1);
        i_mask <= 1'b1;
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        i_mask <= 1'b0;
        rdc(IDX_DATA, 32'ha5);
        rdc(IDX_STATUS, 32'he0);
        rdc(IDX_DATA, 32'ha5);
        rdc(IDX_STATUS, 32'hc0);
        apb(1'b1, IDX_ISTAT, 32'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
    endtask : t_rx

    task automatic t_idle();
        repeat (200) @(posedge clk);
        rdc(IDX_STATUS, 32'hd0);
        chk({31'h0, irq}, 32'h1);
        rdc(IDX_ISTAT, 32'h2);
        settle();
        rdc(IDX_STATUS, 32'hc0);
    endtask : t_idle

    task automatic t_rx_more();
        send(9'h03c, 1'b0);
        send(9'h0c3, 1'b0);
        rdc(IDX_STATUS, 32'he8);
        rdc(IDX_DATA, 32'h3c);
        settle();
        send(9'h000, 1'b1);
        apb(1'b0, IDX_STATUS, 32'h0);
        chk(rd & 32'h2, 32'h2);
        settle();
        apb(1'b1, IDX_CTL1, 32'h14);
        send(9'h1a5, 1'b0);
        rdc(IDX_CTL1, 32'h94);
        rdc(IDX_STATUS, 32'he1);
        rdc(IDX_DATA, 32'ha5);
    endtask : t_rx_more

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    initial begin
        {rst_b, psel, penable, pwrite, i_mask, start, brk} = '0;
        {paddr, pwdata, word} = '0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_regs();
        t_rx();
        t_idle();
        t_rx_more();
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        final_report();
    end
    // nine follows the word-length bit for the ninth-bit frame
    always @(posedge clk) begin
        if (!rst_b) nine <= 1'b0;
        else if (psel && pwrite && paddr == {IDX_CTL1, 2'b00})
            nine <= pwdata[C1_M];
    end
endmodule : test_srx_status
